// ### dv/otp_array_model.sv
// behavioural otp array answering block requests after a set delay
`timescale 1ns/100ps
`default_nettype none
module otp_array_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic otpReq,
    input wire logic [4:0] otpBlock,
    input wire logic [3:0] slow,
    output logic otpValid,
    output logic [71:0] otpCodeword
);
    logic [71:0] code [25];
    logic [3:0] waited;
    // data toggles outside an answer so a stale word never looks valid
    always_ff @(posedge clk) begin
        if (rst || !otpReq || otpValid) begin
            waited <= 4'h0;
            otpValid <= 1'b0;
            otpCodeword <= rst ? 72'h0 : ~otpCodeword;
        end else if (waited >= slow) begin
            otpValid <= 1'b1;
            otpCodeword <= code[otpBlock];
        end else begin
            waited <= waited + 4'h1;
            otpCodeword <= ~otpCodeword;
        end
    end
endmodule : otp_array_model
`default_nettype wire

// ### dv/otp_loader_props.sv
// port assertions for the otp shadow loader
`timescale 1ns/100ps
`default_nettype none
module otp_loader_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic otpReq,
    input wire logic [4:0] otpBlock,
    input wire logic otpValid,
    input wire logic loaderBusy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // block requests: held, then check and apply, then the next index
    a_req_holds: assert property (otpReq && !otpValid |=> otpReq && $stable(otpBlock))
        else $error("otp request dropped");
    a_block_step: assert property (otpReq && otpValid && otpBlock != 5'h18 |=>
        !otpReq ##1 !otpReq ##1 otpReq && otpBlock == $past(otpBlock, 3) + 5'h1)
        else $error("bad block step");
    a_last_idle: assert property (otpReq && otpValid && otpBlock == 5'h18 |=>
        ##2 !loaderBusy) else $error("no idle after last");
    a_req_busy: assert property (otpReq |-> loaderBusy)
        else $error("request while idle");
    a_defaults_first: assert property ($fell(rst) |-> loaderBusy && !otpReq ##1
        otpReq && otpBlock == 5'h0) else $error("defaults not first");
    // register answers, latched in the setup cycle
    a_unmapped_err: assert property (psel && !penable && (paddr[9:2] > 8'hd4 ||
        (paddr[9:2] > 8'hc7 && paddr[9:2] < 8'hd0)) |=> pslverr && prdata == 32'h0)
        else $error("unmapped accepted");
    a_shadow_read: assert property (psel && !penable && paddr[9:2] <= 8'hc7 |=>
        !pslverr && prdata[31:8] == 24'h0) else $error("shadow read wrong");
    a_busy_status: assert property (psel && !penable && !pwrite &&
        paddr[9:2] == 8'hd0 |=> prdata[2] == $past(loaderBusy)) else $error("busy bit wrong");
    c_block: cover property (otpReq && otpValid);
    c_load_end: cover property ($fell(loaderBusy));
    c_slverr: cover property (pslverr && penable);
endmodule : otp_loader_props
bind otp_secded_shadow_loader otp_loader_props PROPS (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pslverr, .otpReq, .otpBlock, .otpValid, .loaderBusy);
`default_nettype wire

// ### dv/otp_secded_shadow_loader_tb.sv
// self-checking bench for the otp shadow loader
`timescale 1ns/100ps
`default_nettype none
module otp_secded_shadow_loader_tb;
    logic clk = 1'b0, rst = 1'b1, wakeReq = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic pready, pslverr, otpReq, otpValid, loaderBusy, e;
    logic [4:0] otpBlock;
    logic [71:0] otpCodeword;
    logic [3:0] slow = 4'hf;
    logic [63:0] dat [25];
    logic bad [25];
    int seed, n_fail, checks;
    always #2.5 clk = ~clk;
    otp_secded_shadow_loader DUT (.clk, .rst, .wakeReq, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .otpReq, .otpBlock, .otpValid, .otpCodeword,
        .loaderBusy);
    otp_array_model OTP (.clk, .rst, .otpReq, .otpBlock, .slow, .otpValid, .otpCodeword);
    // data skips power-of-two slots; p0 closes the overall parity
    function automatic logic [71:0] enc(input logic [63:0] d);
        logic [71:0] c;
        int j;
        c = 72'h0;
        j = 0;
        for (int i = 3; i < 72; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[j];
                j = j + 1;
            end
        end
        for (int k = 0; k < 7; k++) begin
            for (int i = 3; i < 72; i++) begin
                if (i[k] && i != (1 << k)) begin
                    c[1 << k] ^= c[i];
                end
            end
        end
        return {c[71:1], ^c};
    endfunction : enc
    function automatic logic [31:0] shadow(input int i);
        return bad[i / 8] ? 32'h0 : {24'h0, dat[i / 8][8 * (i % 8) +: 8]};
    endfunction : shadow
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] x, input logic xe);
        apb(1'b0, idx, 32'h0);
        checks++;
        if (r !== x || e !== xe) begin
            n_fail++;
            $display("[FAIL] index %h exp %h/%b got %h/%b", idx, x, xe, r, e);
        end
    endtask : rdchk
    // s blocks get one flipped bit, d blocks two distinct ones
    task automatic fill(input int s1, s2, d1, d2);
        int p, q;
        for (int b = 0; b < 25; b++) begin
            dat[b] = {$random(seed), $random(seed)};
            p = {$random(seed)} % 72;
            q = (p + 1 + {$random(seed)} % 71) % 72;
            bad[b] = (b == d1 || b == d2);
            OTP.code[b] = enc(dat[b]);
            if (b == s1 || b == s2 || bad[b]) OTP.code[b][p] ^= 1'b1;
            if (bad[b]) OTP.code[b][q] ^= 1'b1;
        end
    endtask : fill
    task automatic verify(input logic [31:0] st, cb, fb);
        repeat (2) @(posedge clk);
        while (loaderBusy !== 1'b0) @(posedge clk);
        for (int i = 0; i < 200; i++) rdchk(i[7:0], shadow(i), 1'b0);
        rdchk(8'hd0, st, 1'b0);
        rdchk(8'hd2, cb, 1'b0);
        rdchk(8'hd3, fb, 1'b0);
    endtask : verify
    // watchdog far beyond the few thousand cycles the tests take
    initial begin
        #250000;
        n_fail++;
        end_sim;
    end
    initial begin
        seed = 32'had1b;
        fill(3, 9, 5, 20);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h00, 32'h0, 1'b0);
        rdchk(8'hd0, 32'h4, 1'b0);
        verify(32'h3, 32'h9, 32'h14);
        $display("mixed error load done");
        rdchk(8'hc8, 32'h0, 1'b1);
        rdchk(8'hd5, 32'h0, 1'b1);
        apb(1'b1, 8'hd1, 32'h1);
        rdchk(8'hd0, 32'h2, 1'b0);
        apb(1'b1, 8'hd1, 32'h2);
        rdchk(8'hd0, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'ha5);
        rdchk(8'h10, 32'ha5, 1'b0);
        $display("host access done");
        fill(0, 24, -1, -1);
        // corner: lone error in the overall parity bit, data untouched
        OTP.code[7][0] ^= 1'b1;
        slow <= 4'({$random(seed)} % 4);
        apb(1'b1, 8'hd4, 32'h1);
        verify(32'h1, 32'h18, 32'h0);
        $display("soft reset reload done");
        fill(-1, -1, 0, 24);
        // corner: three flips give odd parity with syndrome 75, past the word
        OTP.code[12] ^= 72'h1_0000_0000_0000_0108;
        bad[12] = 1'b1;
        slow <= 4'h0;
        wakeReq <= 1'b1;
        @(posedge clk);
        wakeReq <= 1'b0;
        verify(32'h2, 32'h0, 32'h18);
        $display("wake reload done");
        end_sim;
    end
endmodule : otp_secded_shadow_loader_tb
`default_nettype wire

// ### hdl/otp_loader_pkg.sv
// constants for the otp shadow loader
package otp_loader_pkg;
    // shadow space spans printed offsets 0x0000..0x00c7, one byte each
    localparam int SHADOW_BYTES = 200;
    localparam logic [7:0] SHADOW_LAST_INDEX = 8'hc7;
    localparam logic [7:0] SHADOW_DEFAULT = 8'h00;
    // otp blocks: 64 data bits plus 8 parity bits
    localparam int DATA_BITS = 64;
    localparam int CODE_BITS = 72;
    localparam int SYND_BITS = 7;
    localparam int BYTES_PER_BLOCK = 8;
    localparam int BLOCK_COUNT = 25;
    localparam int BLOCK_W = 5;
    localparam logic [4:0] LAST_BLOCK = 5'h18;
    // extra registers, given as indexes (byte address is four times)
    localparam logic [7:0] IDX_FAULT_STATUS = 8'hd0;
    localparam logic [7:0] IDX_FAULT_CLEAR = 8'hd1;
    localparam logic [7:0] IDX_CORRECTED_BLOCK = 8'hd2;
    localparam logic [7:0] IDX_FAILED_BLOCK = 8'hd3;
    localparam logic [7:0] IDX_MAIN_CONTROL = 8'hd4;
    // field positions
    localparam int SINGLE_FLAG_BIT = 0;
    localparam int DOUBLE_FLAG_BIT = 1;
    localparam int BUSY_BIT = 2;
    localparam int SOFT_RESET_BIT = 0;
    // reset values
    localparam logic [4:0] BLOCK_INDEX_RESET = 5'h00;
endpackage : otp_loader_pkg

// ### hdl/otp_secded_shadow_loader.sv
// wake-up loader copying ecc-checked otp blocks into apb shadow registers
// Function
// RULE_01: bytes 0x0000..0x00c7 have volatile shadow copies at same addresses.
// RULE_02: host access and device control use shadows only; otp only loads.
// RULE_03: on wake, shadows get defaults first, then otp per block result.
// RULE_04: otp moves in 64-bit blocks, each checked on its own.
// RULE_05: single flipped bit is corrected, loaded, single flag set.
// RULE_06: index of corrected block is recorded for the host.
// RULE_07: every single-error block is corrected and loaded independently.
// RULE_08: double error skips the block, keeps defaults, sets double flag.
// RULE_09: index of failed block is recorded for the host.
// RULE_10: codeword is 72 bits: 64 data plus 8 parity.
// RULE_11: parity at 0 and powers of two, data fills the rest ascending.
// RULE_12: p0 is parity over all 72 positions.
// RULE_13: p1 covers positions with bit 0 set.
// RULE_14: p2 covers positions with bit 1 set.
// RULE_15: p4..p64 cover positions with their own bit set.
// RULE_16: host treats device as corrupt if flags survive a reset.
// RULE_17: writing 1 to a clear bit clears the matching flag.
// RULE_18: nonzero syndrome, parity mismatch is single; parity match is double. A mismatch with syndrome above 71 is taken as double here.
`timescale 1ns/100ps
`default_nettype none
module otp_secded_shadow_loader (
    input wire logic clk,
    input wire logic rst,
    input wire logic wakeReq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic otpReq,
    output logic [4:0] otpBlock,
    input wire logic otpValid,
    input wire logic [71:0] otpCodeword,
    output logic loaderBusy
);

    typedef enum logic [2:0] {
        IDLE,
        DEFAULTS,
        REQUEST,
        CHECK,
        APPLY
    } load_state_e;

    load_state_e state;
    logic [7:0] shadow [0:otp_loader_pkg::SHADOW_BYTES-1];
    logic [71:0] codeword;
    logic [6:0] syndrome;
    logic overallOdd;
    logic singleErr;
    logic doubleErr;
    logic [71:0] fixedWord;
    logic [63:0] blockData;
    logic singleFlag;
    logic doubleFlag;
    logic [4:0] correctedBlock;
    logic [4:0] failedBlock;
    logic [7:0] regIndex;
    logic setupPhase;
    logic accessWrite;
    logic mapped;
    logic softReset;
    logic clearSingle;
    logic clearDouble;

    // positions whose index has bit k set
    function automatic logic [71:0] coverMask(input int k);
        logic [71:0] m;
        m = '0;
        for (int i = 1; i < otp_loader_pkg::CODE_BITS; i++) begin
            m[i] = i[k];
        end
        return m;
    endfunction : coverMask

    // data bits sit at non-parity positions, d0 at 3 up to d63 at 71
    function automatic logic [63:0] extractData(input logic [71:0] cw);
        logic [63:0] d;
        int j;
        d = '0;
        j = 0;
        for (int i = 3; i < otp_loader_pkg::CODE_BITS; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[j] = cw[i]; // RULE_11
                j++;
            end
        end
        return d;
    endfunction : extractData

    // one syndrome bit per power-of-two parity group
    // a lone flipped bit shows up in exactly the groups of its set index bits,
    // so the syndrome reads back as the position of that bit
    genvar k;
    generate
        for (k = 0; k < otp_loader_pkg::SYND_BITS; k++) begin : g_synd
            assign syndrome[k] = ^(codeword & coverMask(k)); // RULE_13 RULE_14 RULE_15
        end
    endgenerate

    // p0 makes the whole word even, so an odd sum means an odd error count
    assign overallOdd = ^codeword; // RULE_12

    // classify and correct; a syndrome beyond position 71 cannot be fixed
    always_comb begin
        fixedWord = codeword;
        singleErr = 1'b0;
        doubleErr = 1'b0;
        if (overallOdd) begin
            if (syndrome < 7'(otp_loader_pkg::CODE_BITS)) begin
                singleErr = 1'b1; // RULE_18
                fixedWord[syndrome] = ~codeword[syndrome]; // RULE_05
            end else begin
                doubleErr = 1'b1;
            end
        end else if (syndrome != 7'h00) begin
            doubleErr = 1'b1; // RULE_18
        end
    end

    assign blockData = extractData(fixedWord); // RULE_10

    // apb decode: shadow bytes are indexes, byte address is four times that
    assign regIndex = paddr[9:2];
    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite & ~pslverr;
    assign softReset = accessWrite && regIndex == otp_loader_pkg::IDX_MAIN_CONTROL
        && pwdata[otp_loader_pkg::SOFT_RESET_BIT];
    assign clearSingle = accessWrite && regIndex == otp_loader_pkg::IDX_FAULT_CLEAR
        && pwdata[otp_loader_pkg::SINGLE_FLAG_BIT];
    assign clearDouble = accessWrite && regIndex == otp_loader_pkg::IDX_FAULT_CLEAR
        && pwdata[otp_loader_pkg::DOUBLE_FLAG_BIT];

    // only aligned words inside the low index window are answered
    always_comb begin
        mapped = 1'b0;
        if (paddr[31:10] == 22'h000000 && paddr[1:0] == 2'h0) begin
            mapped = regIndex <= otp_loader_pkg::SHADOW_LAST_INDEX
                || (regIndex >= otp_loader_pkg::IDX_FAULT_STATUS
                && regIndex <= otp_loader_pkg::IDX_MAIN_CONTROL);
        end
    end

    // zero-wait slave: data and error are latched in the setup cycle
    assign pready = 1'b1;

    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= ~mapped;
        end
    end

    // read mux latched at setup, so prdata is a flop through the access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setupPhase) begin
            prdata <= 32'h00000000;
            if (mapped && !pwrite) begin
                if (regIndex <= otp_loader_pkg::SHADOW_LAST_INDEX) begin
                    prdata[7:0] <= shadow[regIndex]; // RULE_02
                end else begin
                    case (regIndex)
                        otp_loader_pkg::IDX_FAULT_STATUS: begin
                            prdata[otp_loader_pkg::SINGLE_FLAG_BIT] <= singleFlag;
                            prdata[otp_loader_pkg::DOUBLE_FLAG_BIT] <= doubleFlag;
                            prdata[otp_loader_pkg::BUSY_BIT] <= loaderBusy;
                        end
                        otp_loader_pkg::IDX_CORRECTED_BLOCK: prdata[4:0] <= correctedBlock;
                        otp_loader_pkg::IDX_FAILED_BLOCK: prdata[4:0] <= failedBlock;
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // load sequencer: defaults, then one otp block at a time
    // wake and soft reset requests are ignored while a load runs
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= DEFAULTS;
        end else begin
            case (state)
                IDLE: begin
                    if (wakeReq || softReset) begin
                        state <= DEFAULTS; // RULE_03
                    end
                end
                DEFAULTS: state <= REQUEST;
                REQUEST: begin
                    if (otpValid) begin
                        state <= CHECK;
                    end
                end
                CHECK: state <= APPLY;
                APPLY: begin
                    if (otpBlock == otp_loader_pkg::LAST_BLOCK) begin
                        state <= IDLE;
                    end else begin
                        state <= REQUEST;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    assign loaderBusy = state != IDLE;
    assign otpReq = state == REQUEST;

    // block counter restarts with every reload
    always_ff @(posedge clk) begin
        if (rst) begin
            otpBlock <= otp_loader_pkg::BLOCK_INDEX_RESET;
        end else if (state == DEFAULTS) begin
            otpBlock <= otp_loader_pkg::BLOCK_INDEX_RESET;
        end else if (state == APPLY) begin
            otpBlock <= otpBlock + 5'h01; // RULE_04
        end
    end

    // codeword is held from capture through check and apply
    always_ff @(posedge clk) begin
        if (rst) begin
            codeword <= 72'h000000000000000000;
        end else if (state == REQUEST && otpValid) begin
            codeword <= otpCodeword; // RULE_04
        end
    end

    // shadow array: defaults, loader writes, host writes (loader wins)
    // a host write that meets a block apply is lost unless that block failed, so software should
    // wait for the busy bit to drop before tuning shadow bytes
    always_ff @(posedge clk) begin
        if (state == DEFAULTS) begin
            for (int i = 0; i < otp_loader_pkg::SHADOW_BYTES; i++) begin
                shadow[i] <= otp_loader_pkg::SHADOW_DEFAULT; // RULE_03
            end
        end else if (state == APPLY && !doubleErr) begin
            for (int b = 0; b < otp_loader_pkg::BYTES_PER_BLOCK; b++) begin
                // RULE_07
                shadow[8 * otpBlock + b] <= blockData[8 * b +: 8]; // RULE_05 RULE_08
            end
        end else if (accessWrite && regIndex <= otp_loader_pkg::SHADOW_LAST_INDEX) begin
            shadow[regIndex] <= pwdata[7:0]; // RULE_01 RULE_02
        end
    end

    // single flag: a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            singleFlag <= 1'b0;
        end else if (state == DEFAULTS) begin
            singleFlag <= 1'b0;
        end else if (state == APPLY && singleErr) begin
            singleFlag <= 1'b1; // RULE_05
        end else if (clearSingle) begin
            singleFlag <= 1'b0; // RULE_17
        end
    end

    // double flag: same priority, so a clear never hides a fresh failure
    always_ff @(posedge clk) begin
        if (rst) begin
            doubleFlag <= 1'b0;
        end else if (state == DEFAULTS) begin
            doubleFlag <= 1'b0;
        end else if (state == APPLY && doubleErr) begin
            doubleFlag <= 1'b1; // RULE_08
        end else if (clearDouble) begin
            doubleFlag <= 1'b0; // RULE_17
        end
    end

    // corrected index keeps the latest single-error block
    always_ff @(posedge clk) begin
        if (rst || state == DEFAULTS) begin
            correctedBlock <= otp_loader_pkg::BLOCK_INDEX_RESET;
        end else if (state == APPLY && singleErr) begin
            correctedBlock <= otpBlock; // RULE_06
        end
    end

    // failed index keeps the latest block left at its defaults
    always_ff @(posedge clk) begin
        if (rst || state == DEFAULTS) begin
            failedBlock <= otp_loader_pkg::BLOCK_INDEX_RESET;
        end else if (state == APPLY && doubleErr) begin
            failedBlock <= otpBlock; // RULE_09
        end
    end

endmodule : otp_secded_shadow_loader
`default_nettype wire
